// File: logic/switch_host_defines.svh
// Constants for the high-side switch host controller: register map, fields, timing.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
//
// Overview of operation
// - Host keeps enable low until supply is reliably above undervoltage.
// - Host waits 40 us (switch on) or 70 us (off) after diag enable rises, unless the rise lands mid-conversion.
// - Host allows 180 us for current sense to settle after enable rises, unless the rise lands mid-conversion.
// - Host allows 20 us for sense to go inactive after diag enable falls.
// - Host allows 20 us for current sense to settle after a load step, unless the step lands mid-conversion.
// - Host waits 60 us after changing sense select before sampling, unless the change lands mid-conversion.
`ifndef SWITCH_HOST_DEFINES_SVH
`define SWITCH_HOST_DEFINES_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SAMPLE 12'h008
`define ADDR_W 12

// Control register fields
`define CTRL_ENABLE 0
`define CTRL_DIAG 1
`define CTRL_HOLD 2
`define CTRL_SEL_LO 3
`define CTRL_SEL_HI 4
`define CTRL_SUPPLY_OK 5
`define CTRL_LOAD_STEP 6
`define CTRL_SAMPLE 7
`define CTRL_W 6
`define CTRL_RESET 6'h00

// Status register fields
`define STAT_FAULT 0
`define STAT_VALID 1
`define STAT_EN_PIN 2
`define STAT_DIAG_PIN 3
`define STAT_SEL_LO 4
`define STAT_SEL_HI 5
`define STAT_FAULT_SEEN 6
`define STAT_QUIET 7
`define STAT_BUSY 8

// Sense select codes, bit 0 is the first select pin
`define SEL_CURRENT 2'h0
`define SEL_TEMPERATURE 2'h1
`define SEL_VOLTAGE 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Sample width from the external converter
`define SAMPLE_W 12
`define CNT_W 16

// Timing, figures in ns
`define CLK_PERIOD_NS 4
`define T_DIAG_ON_SW_ON_NS 40000
`define T_DIAG_ON_SW_OFF_NS 70000
`define T_EN_ON_NS 180000
`define T_DIAG_OFF_NS 20000
`define T_LOAD_STEP_NS 20000
`define T_SELECT_NS 60000

`endif

// File: logic/switch_host_pkg.sv
// Types for the high-side switch host controller.
// Assumes the defines header is compiled alongside.
package switch_host_pkg;
    // Sense path sequencing states
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_SETTLE = 4'h2,
        S_READY = 4'h4,
        S_CONVERT = 4'h8
    } sense_state_t;
endpackage

// File: logic/settle_timer.sv
// Down-counting settle timer that keeps the longest pending wait.
// Assumes load pulses are one cycle wide.
`include "switch_host_defines.svh"
module settle_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Load request
    input wire logic load,
    input wire logic [`CNT_W-1:0] count,
    // Expiry level
    output logic done
);
    logic [`CNT_W-1:0] cnt;

    // Load keeps the longer of pending and new wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (load && count > cnt) begin
            cnt <= count;
        end else if (cnt != '0) begin
            cnt <= cnt - `CNT_W'(1);
        end
    end

    assign done = (cnt == '0);
endmodule

// File: logic/switch_host.sv
// Host controller for a single-channel smart high-side switch.
// Assumes pins are synchronous to CLK and an external converter digitises sense.
//
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`include "switch_host_defines.svh"
module switch_host #(
    parameter int unsigned DIAG_ON_SW_ON_CYC =
        (`T_DIAG_ON_SW_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned DIAG_ON_SW_OFF_CYC =
        (`T_DIAG_ON_SW_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned EN_ON_CYC = (`T_EN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned DIAG_OFF_CYC =
        (`T_DIAG_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned LOAD_STEP_CYC =
        (`T_LOAD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned SELECT_CYC = (`T_SELECT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // AXI4-Lite write address and data
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [`ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [`ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    // Switch control pins
    output logic ENABLE,
    output logic DIAGNOSTIC_ENABLE,
    output logic HOLD,
    output logic SENSE_SELECT_FIRST,
    output logic SENSE_SELECT_SECOND,
    // Switch status pin, open-drain, low on fault
    input wire logic FAULT_STATUS_OUTPUT_N,
    // External converter on the analog sense output
    output logic SAMPLE_REQ,
    input wire logic SAMPLE_DONE,
    input wire logic [`SAMPLE_W-1:0] SAMPLE_DATA
);
    switch_host_pkg::sense_state_t state;
    logic [`CTRL_W-1:0] ctrl;
    logic aw_got, w_got, write_now;
    logic [`ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic load_step_req, sample_cmd;
    logic fault_seen;
    logic [`SAMPLE_W-1:0] sample;
    logic next_enable, next_diag;
    logic [1:0] next_sel;
    logic tmr_load, tmr_done;
    logic [`CNT_W-1:0] tmr_count;
    logic fault_now;
    logic [31:0] rd_mux;
    logic rd_ok;

    assign fault_now = ~FAULT_STATUS_OUTPUT_N;
    assign write_now = aw_got && w_got && !BVALID;

    // Write address channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            AWREADY <= 1'b0;
            aw_got <= 1'b0;
            aw_addr <= '0;
        end else if (AWVALID && AWREADY) begin
            AWREADY <= 1'b0;
            aw_got <= 1'b1;
            aw_addr <= AWADDR;
        end else if (write_now) begin
            aw_got <= 1'b0;
        end else if (!aw_got && !BVALID) begin
            AWREADY <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WREADY <= 1'b0;
            w_got <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (WVALID && WREADY) begin
            WREADY <= 1'b0;
            w_got <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
        end else if (write_now) begin
            w_got <= 1'b0;
        end else if (!w_got && !BVALID) begin
            WREADY <= 1'b1;
        end
    end

    // Write response once both halves are in
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BVALID <= 1'b0;
            BRESP <= `RESP_OKAY;
        end else if (write_now) begin
            BVALID <= 1'b1;
            BRESP <= (aw_addr == `REG_CTRL || aw_addr == `REG_STATUS) ? `RESP_OKAY
                                                                      : `RESP_SLVERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Control register and one-shot command bits
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl <= `CTRL_RESET;
            load_step_req <= 1'b0;
            sample_cmd <= 1'b0;
        end else begin
            load_step_req <= 1'b0;
            sample_cmd <= 1'b0;
            if (write_now && aw_addr == `REG_CTRL && w_strb[0]) begin
                ctrl <= w_data[`CTRL_W-1:0];
                load_step_req <= w_data[`CTRL_LOAD_STEP];
                sample_cmd <= w_data[`CTRL_SAMPLE];
            end
        end
    end

    // Sticky fault flag, cleared by writing one; a new fault wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fault_seen <= 1'b0;
        end else if (fault_now) begin
            fault_seen <= 1'b1;
        end else if (write_now && aw_addr == `REG_STATUS && w_strb[0]
                     && w_data[`STAT_FAULT_SEEN]) begin
            fault_seen <= 1'b0;
        end
    end

    // Pin targets from control
    always_comb begin
        next_enable = ctrl[`CTRL_ENABLE] && ctrl[`CTRL_SUPPLY_OK];
        next_diag = ctrl[`CTRL_DIAG];
        next_sel = ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];
    end

    // Drive switch pins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ENABLE <= 1'b0;
            DIAGNOSTIC_ENABLE <= 1'b0;
            HOLD <= 1'b0;
            SENSE_SELECT_FIRST <= 1'b0;
            SENSE_SELECT_SECOND <= 1'b0;
        end else begin
            ENABLE <= next_enable;
            DIAGNOSTIC_ENABLE <= next_diag;
            // hold pin keeps device latched off
            HOLD <= ctrl[`CTRL_HOLD];
            SENSE_SELECT_FIRST <= next_sel[0];
            SENSE_SELECT_SECOND <= next_sel[1];
        end
    end
    // Settle wait for pin edges; longest event of the cycle wins
    always_comb begin
        tmr_count = '0;
        // diag rise wait by switch state
        if (next_diag && !DIAGNOSTIC_ENABLE) begin
            tmr_count = next_enable ? `CNT_W'(DIAG_ON_SW_ON_CYC) : `CNT_W'(DIAG_ON_SW_OFF_CYC);
        end
        if (next_enable && !ENABLE && `CNT_W'(EN_ON_CYC) > tmr_count) begin
            tmr_count = `CNT_W'(EN_ON_CYC);
        end
        if (next_sel != {SENSE_SELECT_SECOND, SENSE_SELECT_FIRST}
            && `CNT_W'(SELECT_CYC) > tmr_count) begin
            tmr_count = `CNT_W'(SELECT_CYC);
        end
        if (!next_diag && DIAGNOSTIC_ENABLE && `CNT_W'(DIAG_OFF_CYC) > tmr_count) begin
            tmr_count = `CNT_W'(DIAG_OFF_CYC);
        end
        if (load_step_req && `CNT_W'(LOAD_STEP_CYC) > tmr_count) begin
            tmr_count = `CNT_W'(LOAD_STEP_CYC);
        end
        tmr_load = (tmr_count != '0);
    end
    settle_timer u_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Sense sequencing: settle, ready, convert
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= switch_host_pkg::S_IDLE;
            SAMPLE_REQ <= 1'b0;
            sample <= '0;
        end else begin
            SAMPLE_REQ <= 1'b0;
            case (state)
                switch_host_pkg::S_IDLE: begin
                    if (DIAGNOSTIC_ENABLE) begin
                        state <= switch_host_pkg::S_SETTLE;
                    end
                end
                switch_host_pkg::S_SETTLE: begin
                    if (!DIAGNOSTIC_ENABLE) begin
                        state <= switch_host_pkg::S_IDLE;
                    end else if (tmr_done && !tmr_load) begin
                        state <= switch_host_pkg::S_READY;
                    end
                end
                switch_host_pkg::S_READY: begin
                    if (!DIAGNOSTIC_ENABLE) begin
                        state <= switch_host_pkg::S_IDLE;
                    end else if (tmr_load) begin
                        state <= switch_host_pkg::S_SETTLE;
                    end else if (sample_cmd) begin
                        SAMPLE_REQ <= 1'b1;
                        state <= switch_host_pkg::S_CONVERT;
                    end
                end
                switch_host_pkg::S_CONVERT: begin
                    if (SAMPLE_DONE) begin
                        sample <= SAMPLE_DATA;
                        state <= (tmr_load || !DIAGNOSTIC_ENABLE) ? switch_host_pkg::S_SETTLE
                                                                  : switch_host_pkg::S_READY;
                    end
                end
                default: begin
                    state <= switch_host_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Read data selection
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        case (ARADDR)
            `REG_CTRL: begin
                rd_mux[`CTRL_W-1:0] = ctrl;
            end
            `REG_STATUS: begin
                rd_mux[`STAT_FAULT] = fault_now;
                rd_mux[`STAT_VALID] = (state == switch_host_pkg::S_READY);
                rd_mux[`STAT_EN_PIN] = ENABLE;
                rd_mux[`STAT_DIAG_PIN] = DIAGNOSTIC_ENABLE;
                rd_mux[`STAT_SEL_LO] = SENSE_SELECT_FIRST;
                rd_mux[`STAT_SEL_HI] = SENSE_SELECT_SECOND;
                rd_mux[`STAT_FAULT_SEEN] = fault_seen;
                rd_mux[`STAT_QUIET] = !DIAGNOSTIC_ENABLE && tmr_done;
                rd_mux[`STAT_BUSY] = (state == switch_host_pkg::S_CONVERT);
            end
            `REG_SAMPLE: begin
                rd_mux[`SAMPLE_W-1:0] = sample;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read channel
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= `RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RDATA <= rd_mux;
            RRESP <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end else if (!RVALID) begin
            ARREADY <= 1'b1;
        end
    end
endmodule

// File: verification/switch_host_assertions.sv
// Checker for switch_host: settle waits before sampling, pin update, bus answers.
// Assumes it is bound to switch_host and sees only its ports.
module switch_host_checker #(
    parameter int unsigned DIAG_ON_SW_ON_CYC = 10,
    parameter int unsigned EN_ON_CYC = 10,
    parameter int unsigned SELECT_CYC = 10
) (
    // Clock, reset and bus handshakes
    input wire logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID,
    input wire logic ARVALID, ARREADY, RVALID,
    input wire logic [11:0] AWADDR,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // Switch pins and converter request
    input wire logic ENABLE, DIAGNOSTIC_ENABLE, SENSE_SELECT_FIRST, SENSE_SELECT_SECOND,
    input wire logic SAMPLE_REQ
);
    logic [15:0] dia_cnt, en_cnt, sel_cnt;
    logic [3:0] pin_q, w_pins;
    logic aw_ctrl, w_ok;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Saturating counts since diag rise, enable rise and select change
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_q <= 4'h0;
            dia_cnt <= 16'hFFFF;
            en_cnt <= 16'hFFFF;
            sel_cnt <= 16'hFFFF;
        end else begin
            pin_q <= {DIAGNOSTIC_ENABLE, ENABLE, SENSE_SELECT_SECOND, SENSE_SELECT_FIRST};
            dia_cnt <= (DIAGNOSTIC_ENABLE && !pin_q[3]) ? 16'h0 : dia_cnt + {15'h0, ~&dia_cnt};
            en_cnt <= (ENABLE && !pin_q[2]) ? 16'h0 : en_cnt + {15'h0, ~&en_cnt};
            sel_cnt <= ({SENSE_SELECT_SECOND, SENSE_SELECT_FIRST} != pin_q[1:0]) ? 16'h0 :
                sel_cnt + {15'h0, ~&sel_cnt};
        end
    end
    // Target and pin image of the write in flight
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_ctrl <= 1'b0;
            w_ok <= 1'b0;
            w_pins <= 4'h0;
        end else begin
            if (AWVALID && AWREADY) aw_ctrl <= (AWADDR == 12'h000);
            if (WVALID && WREADY) w_ok <= WSTRB[0];
            if (WVALID && WREADY) w_pins <= {WDATA[4:3], WDATA[1], WDATA[0] & WDATA[5]};
        end
    end
    a_diag_settle: assert property (
        SAMPLE_REQ |-> DIAGNOSTIC_ENABLE && dia_cnt + 32'h1 >= DIAG_ON_SW_ON_CYC)
        else $error("sample requested before diag settle");
    a_enable_settle: assert property (
        SAMPLE_REQ && ENABLE |-> en_cnt + 32'h1 >= EN_ON_CYC)
        else $error("sample requested before enable settle");
    a_select_settle: assert property (
        SAMPLE_REQ |-> sel_cnt + 32'h1 >= SELECT_CYC)
        else $error("sample requested before select settle");
    a_pins_follow: assert property (
        $rose(BVALID) && aw_ctrl && w_ok |=>
        {SENSE_SELECT_SECOND, SENSE_SELECT_FIRST, DIAGNOSTIC_ENABLE, ENABLE} == w_pins)
        else $error("pins differ from control write");
    a_sample_pulse: assert property (SAMPLE_REQ |=> !SAMPLE_REQ)
        else $error("sample request longer than one cycle");
    a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
        else $error("write response late");
    a_read_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
        else $error("read response late");
    a_write_busy: assert property (AWVALID && AWREADY |=> !AWREADY [*2])
        else $error("write address ready while busy");
    a_read_busy: assert property (ARVALID && ARREADY |=> !ARREADY)
        else $error("read address ready while busy");
    c_sample: cover property (SAMPLE_REQ);
    c_ctrl_write: cover property ($rose(BVALID) && aw_ctrl);
    c_read: cover property (ARVALID && ARREADY);
endmodule

bind switch_host switch_host_checker #(.DIAG_ON_SW_ON_CYC(DIAG_ON_SW_ON_CYC),
    .EN_ON_CYC(EN_ON_CYC), .SELECT_CYC(SELECT_CYC)) chk_u (.*);

// File: verification/switch_device_model.sv
// Behavioural switch device and sense converter facing the host controller.
// Assumes pins are synchronous to CLK; the bench injects trips and sense values.
module switch_device_model #(
    parameter int unsigned RETRY_CYC = 40
) (
    // Clock, reset and host pins
    input wire logic CLK, RST_N, ENABLE, HOLD, SAMPLE_REQ,
    // Bench stimulus: trip, cooled below hysteresis, converter delay and value
    input wire logic trip, cooled,
    input wire logic [3:0] conv_lat,
    input wire logic [11:0] sense_val,
    // Status pin and converter result
    output logic FAULT_STATUS_OUTPUT_N, SAMPLE_DONE,
    output logic [11:0] SAMPLE_DATA
);
    logic fault;
    logic [15:0] retry;
    logic [3:0] conv;
    assign FAULT_STATUS_OUTPUT_N = !fault;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fault <= 1'b0;
            retry <= 16'h0;
        end else if (trip && ENABLE && !fault) begin
            fault <= 1'b1;
            retry <= 16'(RETRY_CYC);
        end else if (retry != 16'h0) begin
            retry <= retry - 16'h1;
        end else if (!HOLD && cooled) begin
            fault <= 1'b0;
        end
    end
    // Converter answers after a delay; data line toggles while idle
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            conv <= 4'h0;
            SAMPLE_DONE <= 1'b0;
            SAMPLE_DATA <= 12'h000;
        end else begin
            SAMPLE_DONE <= (conv == 4'h1);
            SAMPLE_DATA <= (conv == 4'h1) ? sense_val : ~SAMPLE_DATA;
            conv <= SAMPLE_REQ ? conv_lat + 4'h1 : conv - {3'h0, conv != 4'h0};
        end
    end
endmodule

// File: verification/tb_switch_host.sv
// Self-checking bench for switch_host with a device model on its pins.
// Assumes the defines header is on the include path.
`include "switch_host_defines.svh"
module tb_switch_host;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RST_N = 1'b0, trip = 1'b0, cooled = 1'b0, bh = 1'b0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000, sense_val = 12'h000, SAMPLE_DATA;
    logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
    logic [31:0] WDATA = 32'h0, RDATA, d;
    logic [3:0] WSTRB = 4'h0, conv_lat = 4'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_REQ, SAMPLE_DONE;
    logic ENABLE, DIAGNOSTIC_ENABLE, HOLD, SENSE_SELECT_FIRST, SENSE_SELECT_SECOND;
    logic FAULT_STATUS_OUTPUT_N;
    logic [1:0] BRESP, RRESP;
    logic [1:0] sel_tab[3] = '{`SEL_CURRENT, `SEL_TEMPERATURE, `SEL_VOLTAGE};
    logic [5:0] sh = 6'h00;
    logic [33:0] q[$];
    logic [4:0] pq[$];
    int n_fail = 0, cmp_count = 0, cyc = 0;

    // Short settle and retry figures keep the run brief
    localparam int unsigned dia_on_cyc = 20, dia_off_cyc = 30, en_on_cyc = 60;
    localparam int unsigned dia_fall_cyc = 10, step_cyc = 12, sel_cyc = 25, retry_cyc = 40;

    switch_host #(.DIAG_ON_SW_ON_CYC(dia_on_cyc), .DIAG_ON_SW_OFF_CYC(dia_off_cyc),
        .EN_ON_CYC(en_on_cyc), .DIAG_OFF_CYC(dia_fall_cyc), .LOAD_STEP_CYC(step_cyc),
        .SELECT_CYC(sel_cyc)) dut_u (.*);
    switch_device_model #(.RETRY_CYC(retry_cyc)) dev_u (.*);

    // Clock
    always #2 CLK = ~CLK;

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Bus write; notes the response and the pin image it should leave
    task automatic wr(input logic [11:0] a, input logic [31:0] dw, input logic [3:0] s);
        if (a == `REG_CTRL && s[0]) sh = dw[5:0];
        q.push_back({(a <= 12'h004) ? `RESP_OKAY : `RESP_SLVERR, 32'h0});
        pq.push_back({sh[4:1], sh[0] & sh[5]});
        @(posedge CLK);
        AWADDR <= a;
        AWPROT <= 3'($urandom());
        WDATA <= dw;
        WSTRB <= s;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (AWVALID || WVALID);
        while (!BVALID) @(posedge CLK);
        BREADY <= 1'b0;
    endtask

    // Bus read; notes the expected data and response
    task automatic rd(input logic [11:0] a, input logic [31:0] dx);
        q.push_back({(a <= 12'h008) ? `RESP_OKAY : `RESP_SLVERR, dx});
        @(posedge CLK);
        ARADDR <= a;
        ARPROT <= 3'($urandom());
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        while (!RVALID) @(posedge CLK);
        RREADY <= 1'b0;
    endtask

    task automatic pulse_trip();
        trip <= 1'b1;
        @(posedge CLK);
        trip <= 1'b0;
    endtask

    // Watcher: oldest note against each answer and pin update; timeout
    always @(posedge CLK) begin
        bh <= BVALID && BREADY;
        if (BVALID && BREADY) chk({BRESP, 32'h0}, q.pop_front());
        if (RVALID && RREADY) chk({RRESP, RDATA}, q.pop_front());
        if (bh) chk({29'h0, SENSE_SELECT_SECOND, SENSE_SELECT_FIRST, HOLD,
            DIAGNOSTIC_ENABLE, ENABLE}, {29'h0, pq.pop_front()});
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    // Main sequence
    initial begin
        void'($urandom(32'h8289E99C));
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        rd(`REG_CTRL, 32'h0);
        rd(`REG_SAMPLE, 32'h0);
        wr(12'h00C, 32'h3F, 4'hF);
        rd(12'h00C, 32'h0);
        wr(`REG_CTRL, 32'h3F, 4'hE);
        rd(`REG_CTRL, 32'h0);
        for (int i = 0; i < 6; i++) begin
            d = ($urandom() & 32'hFFFF_FF67) | (32'(sel_tab[i % 3]) << 3);
            wr(`REG_CTRL, d, 4'hF);
            rd(`REG_CTRL, d & 32'h3F);
        end
        // Early sample dropped, settled sample converted
        conv_lat <= 4'($urandom_range(14, 0));
        sense_val <= 12'($urandom());
        wr(`REG_CTRL, 32'h0, 4'hF);
        wr(`REG_CTRL, 32'h23, 4'hF);
        wr(`REG_CTRL, 32'hA3, 4'hF);
        repeat (20) @(posedge CLK);
        rd(`REG_SAMPLE, 32'h0);
        repeat (60) @(posedge CLK);
        rd(`REG_STATUS, 32'h0E);
        wr(`REG_CTRL, 32'hA3, 4'hF);
        repeat (20) @(posedge CLK);
        rd(`REG_SAMPLE, {20'h0, sense_val});
        for (int i = 1; i < 3; i++) begin
            d = 32'h23 | (32'(sel_tab[i]) << 3);
            wr(`REG_CTRL, d, 4'hF);
            wr(`REG_CTRL, d | 32'h80, 4'hF);
            repeat (20) @(posedge CLK);
            rd(`REG_SAMPLE, {20'h0, sense_val});
            sense_val <= 12'($urandom());
            repeat (15) @(posedge CLK);
            wr(`REG_CTRL, d | 32'h80, 4'hF);
            repeat (20) @(posedge CLK);
            rd(`REG_SAMPLE, {20'h0, sense_val});
        end
        // Fault held by the hold pin, then retry interval
        pulse_trip();
        rd(`REG_STATUS, 32'h7F);
        wr(`REG_CTRL, 32'h3F, 4'hF);
        cooled <= 1'b1;
        repeat (60) @(posedge CLK);
        rd(`REG_STATUS, 32'h7F);
        wr(`REG_CTRL, 32'h3B, 4'hF);
        repeat (4) @(posedge CLK);
        wr(`REG_STATUS, 32'h40, 4'hF);
        rd(`REG_STATUS, 32'h3E);
        pulse_trip();
        rd(`REG_STATUS, 32'h7F);
        repeat (60) @(posedge CLK);
        rd(`REG_STATUS, 32'h7E);
        // Diag fall and load step each hold off the quiet flag
        wr(`REG_CTRL, 32'h39, 4'hF);
        rd(`REG_STATUS, 32'h74);
        repeat (15) @(posedge CLK);
        rd(`REG_STATUS, 32'hF4);
        wr(`REG_CTRL, 32'h79, 4'hF);
        rd(`REG_STATUS, 32'h74);
        repeat (15) @(posedge CLK);
        rd(`REG_STATUS, 32'hF4);
        wrap_up();
    end
endmodule
